// File: audio_buf_memory.sv
// buffer memory write logic, host port, flags and interrupt pulse
//
// Functional notes
// - addresses 0..3 hold registers, 4..7 hold user data, in every mode
// - bits shift in first-to-bit-0; a full byte is written to memory
// - user pointer restarts at 4 each block, advances per byte, wraps after 7
// - user/aux half flag low on writing 7, high on writing 5
// - with enable bit 0 set, each user/aux half flag edge pulses interrupt low
// - with its enable set, each cs half flag edge pulses interrupt
// - section flag high after byte 23, low after byte 3; rising edge interrupts
// - modes 0,1: status bit 7 flags differing channel status between channels
// - modes 0,1: status bit 6 flags crc error of buffered channel
// - modes 0,1: status bit 5 flags change in bytes 0..3 between blocks
// - modes 0,1: sub-frame select picks which channel block is stored
// - mode 0: full 24-byte block at addresses 8..31 in order
// - mode 0: cs half flag low after byte 23, high at byte 15
// - mode 1: bytes 0..3 at 8..11; remaining bytes cycle through 12..15
// - mode 1: cs half flag high at byte 1, toggles every second byte
// - mode 1: section flag high after byte 23, low after byte 3
// - mode 1: four aux bits per sub-frame cycle through 16..31
// - mode 2: channel A at 8..15, B at 16..23, mode 1 layout
// - mode 2: bits 7 and 6 flag crc errors of A and B
// - mode 2: bit 5 flags change of bytes 0..3 in either channel
// - sub-frame select low picks sub-frame 1, high sub-frame 2; ignored in mode 2
// - frequency counter enable forces the top address bit to zero
`timescale 1ns/1ps
`include "audio_buf_consts.svh"
module audio_buf_memory
  import audio_buf_pkg::*;
#(
  parameter int IRQ_WIDTH = `IRQ_PULSE_CYCLES
) (
  input wire logic core_clk_in, // 10 MHz system clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic sub_stb_in, // one received sub-frame
  input wire logic sub_b_in, // strobe is sub-frame 2
  input wire logic block_start_in, // first sub-frame of a block
  input wire logic user_bit_in, // user bit of this sub-frame
  input wire logic cs_bit_in, // status bit of this sub-frame
  input wire logic [3:0] aux_bits_in, // aux bits, first in bit 0
  input wire logic [4:0] addr_in, // host address
  input wire logic rd_in, // host read strobe
  input wire logic wr_in, // host write strobe
  input wire logic [7:0] wdata_in, // host write data
  output logic [7:0] rdata_out, // host read data
  output logic user_aux_half_flag_out, // user/aux half flag
  output logic cs_half_flag_out, // cs half flag
  output logic cs_section_flag_out, // cs section flag
  output logic irq_b_out // interrupt, active low
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_pipe_reg;
  logic rst_b;
  // two stages so every flop leaves reset on the same edge
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rst_pipe_reg <= 2'b00;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  assign rst_b = rst_pipe_reg[1];

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] cs_addr(input buf_mode_type m, input logic [4:0] ix,
                                         input logic [4:0] base);
    if (m == MODE_CS_FULL)
      cs_addr = `ADDR_CS_A_BASE + ix;
    else if (ix <= `CS_HEAD_LAST)
      cs_addr = base + ix;
    else
      cs_addr = base + `CS_SECTION_OFS + {3'h0, ix[1:0]};
  endfunction

  logic [7:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next, irq_enable_reg_one_reg, irq_enable_reg_one_next;
  logic [7:0] rdata_next;
  buf_mode_type mode;
  logic sel_b;
  assign mode = buf_mode_type'({ctrl1_reg[`CR1_MODE_HI], ctrl1_reg[`CR1_MODE_LO]});
  assign sel_b = ctrl1_reg[`CR1_SUB_SEL] && mode != MODE_DUAL;

  // ---------------------------------------------------------------
  // channel status capture, one per channel
  // ---------------------------------------------------------------
  logic a_done, b_done, a_bad, b_bad, a_chg, b_chg, blk_b_reg, blk_b_next;
  logic [4:0] a_idx, b_idx;
  logic [7:0] a_data, b_data;
  cs_channel_capture cap_a (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b),
    .bit_stb_in(sub_stb_in && !sub_b_in),
    .cs_bit_in(cs_bit_in),
    .block_start_in(block_start_in),
    .byte_done_out(a_done),
    .byte_idx_out(a_idx),
    .byte_data_out(a_data),
    .crc_bad_out(a_bad),
    .changed_out(a_chg)
  );
  cs_channel_capture cap_b (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b),
    .bit_stb_in(sub_stb_in && sub_b_in),
    .cs_bit_in(cs_bit_in),
    .block_start_in(blk_b_reg),
    .byte_done_out(b_done),
    .byte_idx_out(b_idx),
    .byte_data_out(b_data),
    .crc_bad_out(b_bad),
    .changed_out(b_chg)
  );

  // status write ports: c is the buffered (or A) channel, d is B in mode 2
  logic c_we, d_we;
  logic [4:0] c_idx, c_addr, d_addr;
  logic [7:0] c_data;
  assign c_we = mode != MODE_RSVD && (sel_b ? b_done : a_done);
  assign c_idx = sel_b ? b_idx : a_idx;
  assign c_data = sel_b ? b_data : a_data;
  assign c_addr = cs_addr(mode, c_idx, `ADDR_CS_A_BASE);
  assign d_we = mode == MODE_DUAL && b_done;
  assign d_addr = cs_addr(mode, b_idx, `ADDR_CS_B_BASE);

  // ---------------------------------------------------------------
  // user and aux byte assembly
  // ---------------------------------------------------------------
  logic [7:0] u_sh_reg, u_sh_next, x_sh_reg, x_sh_next;
  logic [2:0] u_cnt_reg, u_cnt_next;
  logic [1:0] u_ptr_reg, u_ptr_next;
  logic [3:0] x_ptr_reg, x_ptr_next;
  logic x_ph_reg, x_ph_next, u_we, x_we;
  logic [4:0] u_waddr, x_waddr;

  always_comb
  begin
    logic [2:0] uc;
    logic [1:0] up;
    logic [3:0] xp;
    logic xh;
    uc = block_start_in ? 3'h0 : u_cnt_reg;
    up = block_start_in ? 2'h0 : u_ptr_reg;
    xp = block_start_in ? 4'h0 : x_ptr_reg;
    xh = block_start_in ? 1'b0 : x_ph_reg;
    u_sh_next = u_sh_reg;
    u_cnt_next = u_cnt_reg;
    u_ptr_next = u_ptr_reg;
    x_sh_next = x_sh_reg;
    x_ptr_next = x_ptr_reg;
    x_ph_next = x_ph_reg;
    blk_b_next = blk_b_reg;
    u_we = 1'b0;
    x_we = 1'b0;
    if (sub_stb_in)
    begin
      blk_b_next = block_start_in && !sub_b_in;
      u_sh_next = {user_bit_in, u_sh_reg[7:1]};
      u_cnt_next = uc + 3'h1;
      x_sh_next = {aux_bits_in, x_sh_reg[7:4]};
      x_ph_next = !xh;
      if (uc == 3'h7)
      begin
        u_we = 1'b1;
        u_ptr_next = up + 2'h1;
      end
      else
        u_ptr_next = up;
      // aux bytes exist only in mode 1; two sub-frames fill one
      x_ptr_next = xh ? xp + 4'h1 : xp;
      x_we = xh && mode == MODE_AUX;
    end
  end
  assign u_waddr = `ADDR_USER_BASE + {3'h0, up_w()};
  function automatic logic [1:0] up_w();
    up_w = block_start_in ? 2'h0 : u_ptr_reg;
  endfunction
  assign x_waddr = `ADDR_AUX_BASE + {1'b0, (block_start_in ? 4'h0 : x_ptr_reg)};

  // stream state registers
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      u_sh_reg <= 8'h00;
      u_cnt_reg <= 3'h0;
      u_ptr_reg <= 2'h0;
      x_sh_reg <= 8'h00;
      x_ptr_reg <= 4'h0;
      x_ph_reg <= 1'b0;
      blk_b_reg <= 1'b0;
    end
    else
    begin
      u_sh_reg <= u_sh_next;
      u_cnt_reg <= u_cnt_next;
      u_ptr_reg <= u_ptr_next;
      x_sh_reg <= x_sh_next;
      x_ptr_reg <= x_ptr_next;
      x_ph_reg <= x_ph_next;
      blk_b_reg <= blk_b_next;
    end
  end

  // ---------------------------------------------------------------
  // buffer memory, second port writes from the stream
  // ---------------------------------------------------------------
  logic [7:0] mem [0:31];
  // write regions never overlap within a mode, so all ports may fire together
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 32; i++)
        mem[i] <= 8'h00;
    end
    else
    begin
      if (u_we)
        mem[u_waddr] <= u_sh_next;
      if (x_we)
        mem[x_waddr] <= x_sh_next;
      if (c_we)
        mem[c_addr] <= c_data;
      if (d_we)
        mem[d_addr] <= b_data;
    end
  end

  // ---------------------------------------------------------------
  // flags and sticky status
  // ---------------------------------------------------------------
  logic f0_reg, f0_next, f1_reg, f1_next, f2_reg, f2_next;
  logic [7:0] a_last_reg, a_last_next;
  logic [2:0] st_reg, st_next, st_set;
  logic st_clr;
  always_comb
  begin
    f0_next = f0_reg;
    f1_next = f1_reg;
    f2_next = f2_reg;
    if (u_we && u_waddr == `ADDR_USER_LAST)
      f0_next = 1'b0;
    if (u_we && u_waddr == `ADDR_USER_HALF)
      f0_next = 1'b1;
    if (c_we)
    begin
      if (c_idx == `CS_LAST_BYTE)
        f2_next = 1'b1;
      if (c_idx == `CS_HEAD_LAST)
        f2_next = 1'b0;
      if (mode == MODE_CS_FULL)
      begin
        if (c_idx == `CS_LAST_BYTE)
          f1_next = 1'b0;
        if (c_idx == `CS_MODE0_HALF)
          f1_next = 1'b1;
      end
      else if (c_idx[0])
        f1_next = !c_idx[1];
    end
    // bit order {7,6,5}; mode 2 redefines all three
    a_last_next = a_done ? a_data : a_last_reg;
    if (mode == MODE_DUAL)
      st_set = {a_bad, b_bad, a_chg || b_chg};
    else
      st_set = {b_done && b_data != a_last_reg,
                sel_b ? b_bad : a_bad,
                sel_b ? b_chg : a_chg};
    // a set arriving with the read clear wins
    st_next = (st_clr ? 3'h0 : st_reg) | st_set;
  end

  // flag registers
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      f0_reg <= 1'b0;
      f1_reg <= 1'b0;
      f2_reg <= 1'b0;
      a_last_reg <= 8'h00;
      st_reg <= 3'h0;
    end
    else
    begin
      f0_reg <= f0_next;
      f1_reg <= f1_next;
      f2_reg <= f2_next;
      a_last_reg <= a_last_next;
      st_reg <= st_next;
    end
  end
  assign user_aux_half_flag_out = f0_reg;
  assign cs_half_flag_out = f1_reg;
  assign cs_section_flag_out = f2_reg;

  // ---------------------------------------------------------------
  // host parallel port
  // ---------------------------------------------------------------
  logic [4:0] host_addr;
  logic [7:0] sr1;
  // the top address pin is shared with the counter clock
  assign host_addr = {addr_in[4] && !ctrl1_reg[`CR1_FREQ_COUNTER_ENABLE], addr_in[3:0]};
  assign sr1 = {st_reg, 2'b00, f2_reg, f1_reg, f0_reg};
  assign st_clr = rd_in && host_addr == `ADDR_STATUS && !ctrl1_reg[`CR1_IER_SEL];
  always_comb
  begin
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    irq_enable_reg_one_next = irq_enable_reg_one_reg;
    rdata_next = rdata_out;
    if (wr_in)
    begin
      case (host_addr)
        `ADDR_STATUS: if (ctrl1_reg[`CR1_IER_SEL]) irq_enable_reg_one_next = wdata_in;
        `ADDR_CTRL_ONE: ctrl1_next = wdata_in;
        `ADDR_CTRL_TWO: ctrl2_next = wdata_in;
        default: irq_enable_reg_one_next = irq_enable_reg_one_reg;
      endcase
    end
    if (rd_in)
    begin
      case (host_addr)
        `ADDR_STATUS: rdata_next = ctrl1_reg[`CR1_IER_SEL] ? irq_enable_reg_one_reg : sr1;
        `ADDR_CTRL_ONE: rdata_next = ctrl1_reg;
        `ADDR_CTRL_TWO: rdata_next = ctrl2_reg;
        default: rdata_next = (host_addr < `ADDR_USER_BASE) ? 8'h00 : mem[host_addr];
      endcase
    end
  end

  // host registers
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl1_reg <= `CTRL_ONE_RST;
      ctrl2_reg <= `CTRL_TWO_RST;
      irq_enable_reg_one_reg <= `IER_ONE_RST;
      rdata_out <= 8'h00;
    end
    else
    begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      irq_enable_reg_one_reg <= irq_enable_reg_one_next;
      rdata_out <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // interrupt pulse
  // ---------------------------------------------------------------
  irq_state_type irq_reg, irq_next;
  logic [7:0] irq_cnt_reg, irq_cnt_next;
  logic irq_ev;
  assign irq_ev = (irq_enable_reg_one_reg[`IE_USER_HALF] && f0_next != f0_reg)
               || (irq_enable_reg_one_reg[`IE_CS_HALF] && f1_next != f1_reg)
               || (irq_enable_reg_one_reg[`IE_SECTION] && f2_next && !f2_reg);
  // a new event restarts the pulse rather than queueing a second one
  always_comb
  begin
    irq_next = irq_reg;
    irq_cnt_next = irq_cnt_reg;
    case (irq_reg)
      IRQ_IDLE:
        if (irq_ev)
        begin
          irq_next = IRQ_PULSE;
          irq_cnt_next = 8'(IRQ_WIDTH - 1);
        end
      IRQ_PULSE:
        if (irq_ev)
          irq_cnt_next = 8'(IRQ_WIDTH - 1);
        else if (irq_cnt_reg == 8'h00)
          irq_next = IRQ_IDLE;
        else
          irq_cnt_next = irq_cnt_reg - 8'h01;
      default: irq_next = IRQ_IDLE;
    endcase
  end

  // interrupt registers
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_reg <= IRQ_IDLE;
      irq_cnt_reg <= 8'h00;
    end
    else
    begin
      irq_reg <= irq_next;
      irq_cnt_reg <= irq_cnt_next;
    end
  end
  assign irq_b_out = irq_reg != IRQ_PULSE;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b);
  sequence irq_low_seq;
    !irq_b_out [*4];
  endsequence
  sequence last_user_wr_seq;
    u_we && u_waddr == `ADDR_USER_LAST;
  endsequence
  user_wr_range_a: assert property (u_we |-> u_waddr >= `ADDR_USER_BASE && u_waddr <= `ADDR_USER_LAST)
    else $error("user byte written outside 4..7");
  user_low_a: assert property (last_user_wr_seq |=> !user_aux_half_flag_out)
    else $error("user half flag not low after last byte");
  user_high_a: assert property (u_we && u_waddr == `ADDR_USER_HALF |=> user_aux_half_flag_out)
    else $error("user half flag not high after byte 5");
  irq_user_a: assert property (irq_enable_reg_one_reg[0] && f0_next != f0_reg |=> irq_low_seq)
    else $error("user flag edge gave no low pulse");
  irq_quiet_a: assert property ($rose(irq_b_out) |-> $past(irq_cnt_reg) == 8'h00)
    else $error("interrupt pulse ended early");
  section_set_a: assert property (c_we && c_idx == `CS_LAST_BYTE |=> cs_section_flag_out)
    else $error("section flag not set after byte 23");
  mode0_addr_a: assert property (c_we && mode == MODE_CS_FULL |-> c_addr == `ADDR_CS_A_BASE + c_idx)
    else $error("mode 0 status byte misplaced");
  mode0_half_a: assert property (c_we && mode == MODE_CS_FULL && c_idx == `CS_MODE0_HALF
                                 |=> cs_half_flag_out ##1 cs_half_flag_out)
    else $error("mode 0 cs half flag not high at byte 15");
  aux_range_a: assert property (x_we |-> x_waddr >= `ADDR_AUX_BASE && mode == MODE_AUX)
    else $error("aux byte written outside mode 1 region");
  freq_counter_enable_top_a: assert property (ctrl1_reg[`CR1_FREQ_COUNTER_ENABLE] |-> !host_addr[4])
    else $error("top address bit reachable with counter on");
  sticky_set_a: assert property (st_set[0] |=> st_reg[0])
    else $error("change bit lost");
endmodule

// File: audio_buf_consts.svh
// constants for the received-stream buffer memory block
`ifndef AUDIO_BUF_CONSTS_SVH
`define AUDIO_BUF_CONSTS_SVH
// host address map
`define ADDR_STATUS 5'h00
`define ADDR_CTRL_ONE 5'h02
`define ADDR_CTRL_TWO 5'h03
`define ADDR_USER_BASE 5'h04
`define ADDR_USER_HALF 5'h05
`define ADDR_USER_LAST 5'h07
`define ADDR_CS_A_BASE 5'h08
`define ADDR_CS_B_BASE 5'h10
`define ADDR_AUX_BASE 5'h10
`define CS_SECTION_OFS 5'h04
// channel status byte indices
`define CS_HEAD_LAST 5'h03
`define CS_MODE0_HALF 5'h0F
`define CS_LAST_BYTE 5'h17
// control register one fields
`define CR1_MODE_LO 1
`define CR1_MODE_HI 2
`define CR1_SUB_SEL 3
`define CR1_IER_SEL 4
`define CR1_FREQ_COUNTER_ENABLE 5
// irq enable register one fields
`define IE_USER_HALF 0
`define IE_CS_HALF 1
`define IE_SECTION 2
// reset values
`define CTRL_ONE_RST 8'h00
`define CTRL_TWO_RST 8'h00
`define IER_ONE_RST 8'h00
// channel status crc, reflected polynomial
`define CRC_INIT 8'hFF
`define CRC_POLY 8'hB8
// low pulse width of the interrupt output, in clock cycles
`define IRQ_PULSE_CYCLES 4
`endif

// File: audio_buf_pkg.sv
// types for the received-stream buffer memory block
package audio_buf_pkg;
  typedef enum logic [1:0] {
    MODE_CS_FULL = 2'b00,
    MODE_AUX = 2'b01,
    MODE_DUAL = 2'b10,
    MODE_RSVD = 2'b11
  } buf_mode_type;
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b01,
    IRQ_PULSE = 2'b10
  } irq_state_type;
endpackage

// File: cs_channel_capture.sv
// one channel of channel status: byte assembly, crc check, change detect
`timescale 1ns/1ps
`include "audio_buf_consts.svh"
module cs_channel_capture (
  input wire logic core_clk_in, // system clock
  input wire logic rst_b_in, // synchronised reset, active low
  input wire logic bit_stb_in, // one status bit offered
  input wire logic cs_bit_in, // the status bit
  input wire logic block_start_in, // this bit opens a block
  output logic byte_done_out, // byte complete pulse
  output logic [4:0] byte_idx_out, // index 0..23 of that byte
  output logic [7:0] byte_data_out, // the byte, first bit in bit 0
  output logic crc_bad_out, // pulse: byte 23 mismatch
  output logic changed_out // pulse: bytes 0..3 changed
);
  logic [7:0] sh_reg, sh_next, crc_reg, crc_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [4:0] idx_reg, idx_next, idx_out_next;
  logic [31:0] prev_reg, prev_next;
  logic prev_ok_reg, prev_ok_next, diff_reg, diff_next;
  logic done_next, bad_next, chg_next;
  logic [7:0] data_next;

  // ---------------------------------------------------------------
  // bit assembly and checks
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [2:0] bc;
    logic [4:0] ix;
    logic [7:0] cr;
    logic fb;
    bc = block_start_in ? 3'h0 : cnt_reg;
    ix = block_start_in ? 5'h00 : idx_reg;
    cr = block_start_in ? `CRC_INIT : crc_reg;
    fb = cs_bit_in ^ cr[0];
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    crc_next = crc_reg;
    prev_next = prev_reg;
    prev_ok_next = prev_ok_reg;
    diff_next = diff_reg;
    done_next = 1'b0;
    bad_next = 1'b0;
    chg_next = 1'b0;
    idx_out_next = byte_idx_out;
    data_next = byte_data_out;
    if (bit_stb_in)
    begin
      sh_next = {cs_bit_in, sh_reg[7:1]};
      cnt_next = bc + 3'h1;
      idx_next = ix;
      // the crc byte itself is not folded into the crc
      crc_next = (ix == `CS_LAST_BYTE) ? cr : ((cr >> 1) ^ (fb ? `CRC_POLY : 8'h00));
      if (bc == 3'h7)
      begin
        done_next = 1'b1;
        idx_out_next = ix;
        data_next = sh_next;
        idx_next = (ix == `CS_LAST_BYTE) ? 5'h00 : ix + 5'h01;
        if (ix == `CS_LAST_BYTE)
          bad_next = (cr != sh_next);
        if (ix <= `CS_HEAD_LAST)
        begin
          // compare against the same byte of the previous block
          diff_next = diff_reg | (prev_ok_reg && prev_reg[ix[1:0]*8 +: 8] != sh_next);
          prev_next[ix[1:0]*8 +: 8] = sh_next;
        end
        if (ix == `CS_HEAD_LAST)
        begin
          chg_next = diff_next;
          diff_next = 1'b0;
          prev_ok_next = 1'b1;
        end
      end
    end
  end

  // register stage
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sh_reg <= 8'h00;
      cnt_reg <= 3'h0;
      idx_reg <= 5'h00;
      crc_reg <= `CRC_INIT;
      prev_reg <= 32'h0000_0000;
      prev_ok_reg <= 1'b0;
      diff_reg <= 1'b0;
      byte_done_out <= 1'b0;
      byte_idx_out <= 5'h00;
      byte_data_out <= 8'h00;
      crc_bad_out <= 1'b0;
      changed_out <= 1'b0;
    end
    else
    begin
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      crc_reg <= crc_next;
      prev_reg <= prev_next;
      prev_ok_reg <= prev_ok_next;
      diff_reg <= diff_next;
      byte_done_out <= done_next;
      byte_idx_out <= idx_out_next;
      byte_data_out <= data_next;
      crc_bad_out <= bad_next;
      changed_out <= chg_next;
    end
  end
endmodule

// File: host_model.sv
// host processor model on the parallel buffer port
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk_in, // system clock
  input wire logic [7:0] rdata_in, // read data from the block
  output logic [4:0] addr_out, // host address
  output logic rd_out, // read strobe
  output logic wr_out, // write strobe
  output logic [7:0] wdata_out // write data
);
  // ---------------------------------------------
  // idle port and access tasks
  // ---------------------------------------------
  initial
  begin
    {addr_out, rd_out, wr_out, wdata_out} = '0;
  end
  // released address and data show the inverse, so a stale value never matches
  task automatic put(input logic [4:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
    @(negedge core_clk_in);
    {addr_out, wdata_out, wr_out} = {~a, ~d, 1'b0};
  endtask
  // reads are only issued once the stream is quiet, so no byte is mid-update
  task automatic get(input logic [4:0] a, output logic [7:0] d);
    @(negedge core_clk_in);
    {addr_out, rd_out} = {a, 1'b1};
    @(negedge core_clk_in);
    {addr_out, rd_out} = {~a, 1'b0};
    @(negedge core_clk_in);
    d = rdata_in;
  endtask
endmodule

// File: testbench.sv
// self-checking bench for the buffer memory write logic
`timescale 1ns/1ps
module testbench;
  logic core_clk_in, rst_b_in, sub_stb_in, sub_b_in, block_start_in, user_bit_in, cs_bit_in;
  logic [3:0] aux_bits_in;
  logic [4:0] addr_in;
  logic rd_in, wr_in, uf, cf, sf, irq_b;
  logic [7:0] wdata_in, rdata_out, rv, aux_last;
  logic [7:0] csa [24];
  logic [7:0] csb [24];
  logic [7:0] usr [48];
  int n_mismatch, n_compared, n_fall;
  // ---------------------------------------------
  // clock, design and host
  // ---------------------------------------------
  initial
  begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  audio_buf_memory dut (.core_clk_in, .rst_b_in, .sub_stb_in, .sub_b_in, .block_start_in, .user_bit_in,
    .cs_bit_in, .aux_bits_in, .addr_in, .rd_in, .wr_in, .wdata_in, .rdata_out,
    .user_aux_half_flag_out(uf), .cs_half_flag_out(cf), .cs_section_flag_out(sf), .irq_b_out(irq_b));
  host_model host (.core_clk_in, .rdata_in(rdata_out), .addr_out(addr_in), .rd_out(rd_in), .wr_out(wr_in),
    .wdata_out(wdata_in));
  always @(negedge irq_b) n_fall++;
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // reflected crc, lsb first over bytes 0..22
  function automatic logic [7:0] crc_of(input logic [7:0] b [24]);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 0; i < 184; i++)
      c = (c[0] ^ b[i / 8][i % 8]) ? ((c >> 1) ^ 8'hb8) : (c >> 1);
    return c;
  endfunction
  // half-buffer layout: bytes 0..3 fixed, 4..7 hold bytes 20..23 at block end
  function automatic logic [7:0] cs_at(input logic [7:0] ch [24], input int off);
    return off < 4 ? ch[off] : ch[off + 16];
  endfunction
  // one full block of 384 sub-frames, strobes two cycles apart
  task automatic send_block(input logic diff, input logic bad);
    logic [3:0] x;
    for (int k = 0; k < 24; k++)
    begin
      csa[k] = 8'($urandom);
      csb[k] = csa[k] ^ 8'(diff && k < 4);
    end
    csa[23] = crc_of(csa);
    csb[23] = crc_of(csb) ^ 8'(bad);
    for (int s = 0; s < 384; s++)
    begin
      x = 4'($urandom);
      usr[s / 8][s % 8] = 1'($urandom);
      aux_last = {x, aux_last[7:4]};
      @(negedge core_clk_in);
      {sub_stb_in, sub_b_in, block_start_in, user_bit_in, aux_bits_in} = {1'b1, s[0], s == 0, usr[s / 8][s % 8], x};
      cs_bit_in = s[0] ? csb[s / 16][(s / 2) % 8] : csa[s / 16][(s / 2) % 8];
      @(negedge core_clk_in);
      sub_stb_in = 1'b0;
    end
    repeat (4) @(negedge core_clk_in);
  endtask
  // ---------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    n_mismatch++;
    close_out;
  end
  initial
  begin
    {n_mismatch, n_compared, n_fall} = '0;
    {rst_b_in, sub_stb_in, sub_b_in, block_start_in, user_bit_in, cs_bit_in, aux_bits_in} = '0;
    void'($urandom(37));
    repeat (12) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    check({4'h0, irq_b, uf, cf, sf}, 8'h08);
    host.get(5'h01, rv);
    check(rv, 8'h00);
    // mode 0, sub-frame 1, only the user half interrupt enabled
    host.put(5'h02, 8'h10);
    host.put(5'h00, 8'h01);
    host.put(5'h02, 8'h00);
    send_block(1'b0, 1'b0);
    check(8'(n_fall), 8'h18);
    check({5'h00, uf, cf, sf}, 8'h01);
    for (int a = 4; a < 32; a++)
    begin
      host.get(5'(a), rv);
      check(rv, a < 8 ? usr[a + 40] : csa[a - 8]);
    end
    host.get(5'h00, rv);
    check(rv, 8'h04);
    // mode 1, sub-frame 2 differing with a bad crc
    // only the cs half flag may interrupt here: twelve edges in one block
    host.put(5'h02, 8'h1a);
    host.put(5'h00, 8'h02);
    host.put(5'h02, 8'h0a);
    n_fall = 0;
    send_block(1'b1, 1'b1);
    check(8'(n_fall), 8'h0c);
    for (int a = 8; a < 16; a++)
    begin
      host.get(5'(a), rv);
      check(rv, cs_at(csb, a - 8));
    end
    host.get(5'h1f, rv);
    check(rv, aux_last);
    host.get(5'h00, rv);
    check(rv, 8'he4);
    host.put(5'h02, 8'h2a);
    host.get(5'h18, rv);
    check(rv, csb[0]);
    // mode 2, both channels, channel b crc bad
    // only the section flag may interrupt here: its one rising edge
    host.put(5'h02, 8'h14);
    host.put(5'h00, 8'h04);
    host.put(5'h02, 8'h04);
    n_fall = 0;
    send_block(1'b1, 1'b1);
    check(8'(n_fall), 8'h01);
    for (int a = 8; a < 24; a++)
    begin
      host.get(5'(a), rv);
      check(rv, a < 16 ? cs_at(csa, a - 8) : cs_at(csb, a - 16));
    end
    host.get(5'h00, rv);
    check(rv, 8'h64);
    close_out;
  end
endmodule
